//--- verilog/tifc_pkg.sv
package tifc_pkg;

	// command codes of the byte registers
	localparam logic [7:0] TIFC_ADDR_FAULT_THR = 8'h4F;
	localparam logic [7:0] TIFC_ADDR_FAULT_ACT = 8'h50;
	localparam logic [7:0] TIFC_ADDR_WARN_THR = 8'h51;
	localparam logic [7:0] TIFC_ADDR_VIN_THR = 8'h55;
	localparam logic [7:0] TIFC_ADDR_STAT_INPUT = 8'h7C;
	localparam logic [7:0] TIFC_ADDR_STAT_TEMP = 8'h7D;

	// field positions
	localparam int TIFC_SEL_LSB = 0;
	localparam int TIFC_SEL_MSB = 2;
	localparam int TIFC_RETRY_BIT = 3;
	localparam int TIFC_OVSEL_BIT = 0;
	localparam int TIFC_STAT_FAULT_BIT = 7;
	localparam int TIFC_STAT_WARN_BIT = 6;
	localparam int TIFC_STAT_VINOV_BIT = 7;
	localparam logic [7:0] TIFC_BYTE_ZERO = 8'h00;

	// temperatures in degC
	localparam logic [7:0] TIFC_FAULT_BASE_C = 8'h73;
	localparam logic [7:0] TIFC_FAULT_STEP_C = 8'h05;

	// input rail thresholds in 100 mV units
	localparam logic [7:0] TIFC_VIN_RISE_LO = 8'hA9;
	localparam logic [7:0] TIFC_VIN_RISE_HI = 8'hBA;
	localparam logic [7:0] TIFC_VIN_FALL = 8'h87;

	// retry delay
	localparam int TIFC_CLK_HZ = 10_000_000;
	localparam int TIFC_RETRY_DELAY_MS = 56;
	localparam int TIFC_RETRY_CYCLES = TIFC_RETRY_DELAY_MS * (TIFC_CLK_HZ / 1000);
	localparam int TIFC_CNT_W = 20;

	typedef enum logic [1:0] {
		TIFC_RUN = 2'b00,
		TIFC_LATCHED = 2'b01,
		TIFC_RETRY_WAIT = 2'b10
	} tifc_state_e;

	function automatic logic [7:0] tifc_fault_thr(input logic [2:0] sel);
		tifc_fault_thr = TIFC_FAULT_BASE_C + 8'(TIFC_FAULT_STEP_C * {5'h00, sel});
	endfunction

	// code 101b is not defined for the warning; it maps to the 100b value
	function automatic logic [7:0] tifc_warn_thr(input logic [2:0] sel);
		case (sel)
			3'h0: tifc_warn_thr = 8'h55;
			3'h1: tifc_warn_thr = 8'h5F;
			3'h2: tifc_warn_thr = 8'h64;
			3'h3: tifc_warn_thr = 8'h69;
			3'h4: tifc_warn_thr = 8'h73;
			3'h5: tifc_warn_thr = 8'h73;
			3'h6: tifc_warn_thr = 8'h7D;
			default: tifc_warn_thr = 8'h87;
		endcase
	endfunction

endpackage

//--- verilog/tifc_thermal_input_fault.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - fault threshold code selects 115 degC plus 5 degC per step.
// - temperature is compared digitally against the selected fault threshold.
// - reserved bits of the four limit registers read as zero.
// - overtemperature fault sets its status flag, then acts per retry bit.
// - retry bit clear: latch off until power cycle or enable toggle.
// - retry bit set: restart 56 ms after fault, retrying without limit.
// - warning threshold code decodes to its listed temperature.
// - temperature is compared digitally against the selected warning threshold.
// - reaching the warning threshold sets the warning status flag.
// - input overvoltage always latches off switching, no retry.
// - input overvoltage sets its flag in the input status register.
// - bit 0 selects rising trip 16.9 V or 18.6 V.
// - falling release threshold is fixed at 13.5 V.
// - each register is one byte, single byte write and read.
// - writes act at once; power-up values come from nonvolatile storage.
module tifc_thermal_input_fault
	import tifc_pkg::*;
#(
	parameter logic [TIFC_CNT_W-1:0] RETRY_CYCLES = TIFC_CNT_W'(TIFC_RETRY_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// byte register port, decoded from the serial host link
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// nonvolatile defaults, taken while reset is held
	input wire logic [2:0] nvm_fault_temp_select,
	input wire logic nvm_retry_select,
	input wire logic [2:0] nvm_warning_temp_select,
	input wire logic nvm_ov_rise_select,
	// telemetry and control
	input wire logic [7:0] die_temp_c,
	input wire logic [7:0] power_input_rail,
	input wire logic enable_in,
	// power stage control and status
	output logic convert_en,
	output logic temp_fault_flag,
	output logic temp_warning_flag,
	output logic input_overvoltage_flag
);

	typedef struct packed {
		tifc_state_e state;
		logic [2:0] fault_temp_select;
		logic retry_select;
		logic [2:0] warning_temp_select;
		logic ov_rise_select;
		logic temp_fault_flag;
		logic temp_warning_flag;
		logic input_overvoltage_flag;
		logic ov_active;
		logic [TIFC_CNT_W-1:0] retry_cnt;
		logic [7:0] rdata;
		logic convert_en;
	} tifc_regs_s;

	tifc_regs_s st_ff;
	tifc_regs_s nxt_st;

	logic [7:0] fault_thr;
	logic [7:0] warn_thr;
	logic [7:0] vin_rise;
	logic over_fault;
	logic over_warn;
	logic input_overvoltage_event;
	logic wr_stat_temp;
	logic wr_stat_input;

	always_comb begin
		fault_thr = tifc_fault_thr(st_ff.fault_temp_select);
		warn_thr = tifc_warn_thr(st_ff.warning_temp_select);
		vin_rise = st_ff.ov_rise_select ? TIFC_VIN_RISE_HI : TIFC_VIN_RISE_LO;
		over_fault = (die_temp_c >= fault_thr);
		over_warn = (die_temp_c >= warn_thr);
		input_overvoltage_event = !st_ff.ov_active && (power_input_rail >= vin_rise);
		wr_stat_temp = reg_wr && (reg_addr == TIFC_ADDR_STAT_TEMP);
		wr_stat_input = reg_wr && (reg_addr == TIFC_ADDR_STAT_INPUT);
	end

	always_comb begin
		nxt_st = st_ff;
		// writes land on the next edge and steer the comparators at once
		if (reg_wr) begin
			case (reg_addr)
				TIFC_ADDR_FAULT_THR: nxt_st.fault_temp_select = reg_wdata[TIFC_SEL_MSB:TIFC_SEL_LSB];
				TIFC_ADDR_FAULT_ACT: nxt_st.retry_select = reg_wdata[TIFC_RETRY_BIT];
				TIFC_ADDR_WARN_THR:
					nxt_st.warning_temp_select = reg_wdata[TIFC_SEL_MSB:TIFC_SEL_LSB];
				TIFC_ADDR_VIN_THR: nxt_st.ov_rise_select = reg_wdata[TIFC_OVSEL_BIT];
				default: nxt_st.retry_cnt = st_ff.retry_cnt;
			endcase
		end
		// write one to clear; a new event in the same cycle keeps the flag set
		if (wr_stat_temp && reg_wdata[TIFC_STAT_FAULT_BIT]) begin
			nxt_st.temp_fault_flag = 1'b0;
		end
		if (wr_stat_temp && reg_wdata[TIFC_STAT_WARN_BIT]) begin
			nxt_st.temp_warning_flag = 1'b0;
		end
		if (wr_stat_input && reg_wdata[TIFC_STAT_VINOV_BIT]) begin
			nxt_st.input_overvoltage_flag = 1'b0;
		end
		if (over_warn) begin
			nxt_st.temp_warning_flag = 1'b1;
		end
		// hysteresis: released only below the fixed falling level
		if (power_input_rail >= vin_rise) begin
			nxt_st.ov_active = 1'b1;
		end else if (power_input_rail < TIFC_VIN_FALL) begin
			nxt_st.ov_active = 1'b0;
		end
		if (input_overvoltage_event) begin
			nxt_st.input_overvoltage_flag = 1'b1;
		end
		// temperature flags are set whenever their condition holds, even while off
		if (over_fault) begin
			nxt_st.temp_fault_flag = 1'b1;
		end
		case (st_ff.state)
			TIFC_RUN: begin
				if (input_overvoltage_event) begin
					nxt_st.state = TIFC_LATCHED;
				end else if (over_fault && enable_in) begin
					if (st_ff.retry_select) begin
						nxt_st.state = TIFC_RETRY_WAIT;
						nxt_st.retry_cnt = '0;
					end else begin
						nxt_st.state = TIFC_LATCHED;
					end
				end
			end
			TIFC_RETRY_WAIT: begin
				nxt_st.retry_cnt = st_ff.retry_cnt + TIFC_CNT_W'(1);
				if (input_overvoltage_event) begin
					nxt_st.state = TIFC_LATCHED;
				end else if (!enable_in) begin
					nxt_st.state = TIFC_RUN;
				end else if (st_ff.retry_cnt == RETRY_CYCLES - TIFC_CNT_W'(1)) begin
					nxt_st.state = TIFC_RUN;
				end
			end
			TIFC_LATCHED: begin
				// dropping the enable is the toggle that rearms conversion; a fresh
				// input overvoltage in the same cycle keeps the stage latched
				if (!enable_in && !input_overvoltage_event) begin
					nxt_st.state = TIFC_RUN;
				end
			end
			default: nxt_st.state = TIFC_LATCHED;
		endcase
		nxt_st.convert_en = enable_in && (nxt_st.state == TIFC_RUN);
		// read data is captured on the read strobe and held until the next read
		if (reg_rd) begin
			case (reg_addr)
				TIFC_ADDR_FAULT_THR: nxt_st.rdata = {5'h00, st_ff.fault_temp_select};
				TIFC_ADDR_FAULT_ACT: nxt_st.rdata = {4'h0, st_ff.retry_select, 3'h0};
				TIFC_ADDR_WARN_THR: nxt_st.rdata = {5'h00, st_ff.warning_temp_select};
				TIFC_ADDR_VIN_THR: nxt_st.rdata = {7'h00, st_ff.ov_rise_select};
				TIFC_ADDR_STAT_INPUT: nxt_st.rdata = {st_ff.input_overvoltage_flag, 7'h00};
				TIFC_ADDR_STAT_TEMP:
					nxt_st.rdata = {st_ff.temp_fault_flag, st_ff.temp_warning_flag, 6'h00};
				default: nxt_st.rdata = TIFC_BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff.state <= TIFC_RUN;
			st_ff.fault_temp_select <= nvm_fault_temp_select;
			st_ff.retry_select <= nvm_retry_select;
			st_ff.warning_temp_select <= nvm_warning_temp_select;
			st_ff.ov_rise_select <= nvm_ov_rise_select;
			st_ff.temp_fault_flag <= 1'b0;
			st_ff.temp_warning_flag <= 1'b0;
			st_ff.input_overvoltage_flag <= 1'b0;
			st_ff.ov_active <= 1'b0;
			st_ff.retry_cnt <= '0;
			st_ff.rdata <= TIFC_BYTE_ZERO;
			st_ff.convert_en <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign convert_en = st_ff.convert_en;
	assign temp_fault_flag = st_ff.temp_fault_flag;
	assign temp_warning_flag = st_ff.temp_warning_flag;
	assign input_overvoltage_flag = st_ff.input_overvoltage_flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_hot_in_run;
		(st_ff.state == TIFC_RUN) && over_fault && enable_in && !input_overvoltage_event;
	endsequence

	sequence s_retry_done;
		(st_ff.state == TIFC_RETRY_WAIT) && enable_in && !input_overvoltage_event
			&& (st_ff.retry_cnt == RETRY_CYCLES - TIFC_CNT_W'(1));
	endsequence

	AST_FAULT_CODE: assert property (
		fault_thr == TIFC_FAULT_BASE_C + 8'(TIFC_FAULT_STEP_C * {5'h00, st_ff.fault_temp_select}))
		else $error("fault threshold does not follow code");
	AST_FAULT_FLAG: assert property (
		die_temp_c >= fault_thr |=> temp_fault_flag)
		else $error("fault flag not set on hot die");
	AST_LATCH_OFF: assert property (
		s_hot_in_run and !st_ff.retry_select |=> (st_ff.state == TIFC_LATCHED) && !convert_en)
		else $error("no latch off after fault");
	AST_RETRY_ENTRY: assert property (
		s_hot_in_run and st_ff.retry_select |=> st_ff.state == TIFC_RETRY_WAIT && st_ff.retry_cnt == '0)
		else $error("retry wait not entered");
	AST_RETRY_EXIT: assert property (
		s_retry_done |=> (st_ff.state == TIFC_RUN) && convert_en)
		else $error("no restart after retry delay");
	AST_WARN_101: assert property (
		st_ff.warning_temp_select == 3'h5 |-> warn_thr == 8'h73)
		else $error("warning code 101b not 115 degC");
	AST_WARN_FLAG: assert property (
		die_temp_c >= warn_thr |=> temp_warning_flag)
		else $error("warning flag not set");
	AST_VIN_LATCH: assert property (
		input_overvoltage_event |=> st_ff.state == TIFC_LATCHED && input_overvoltage_flag && !convert_en)
		else $error("no latch off on input overvoltage");
	AST_VIN_RISE: assert property (
		st_ff.ov_rise_select && power_input_rail < TIFC_VIN_RISE_HI && !st_ff.ov_active
			|=> !st_ff.ov_active)
		else $error("rising trip ignores selection");
	AST_VIN_FALL: assert property (
		st_ff.ov_active && power_input_rail >= TIFC_VIN_FALL |=> st_ff.ov_active)
		else $error("overvoltage released above falling level");
	AST_RESERVED: assert property (
		reg_rd && reg_addr == TIFC_ADDR_FAULT_ACT |=> reg_rdata[7:4] == 4'h0 && reg_rdata[2:0] == 3'h0)
		else $error("reserved bits read nonzero");
	AST_WRITE_NOW: assert property (
		reg_wr && reg_addr == TIFC_ADDR_FAULT_THR
			|=> st_ff.fault_temp_select == 3'($past(reg_wdata)))
		else $error("limit write not applied");
	AST_STICKY: assert property (
		temp_warning_flag && !(wr_stat_temp && reg_wdata[TIFC_STAT_WARN_BIT]) |=> temp_warning_flag)
		else $error("warning flag dropped without clear");

	// steps of the latch, the retry wait and the two rising trip levels
	sequence s_latched_enabled;
		(st_ff.state == TIFC_LATCHED) && enable_in;
	endsequence

	sequence s_rearm;
		(st_ff.state == TIFC_LATCHED) && !enable_in && !input_overvoltage_event;
	endsequence

	sequence s_retry_counting;
		(st_ff.state == TIFC_RETRY_WAIT) && enable_in && !input_overvoltage_event
			&& (st_ff.retry_cnt != RETRY_CYCLES - TIFC_CNT_W'(1));
	endsequence

	sequence s_trip_low;
		!st_ff.ov_rise_select && !st_ff.ov_active && (power_input_rail >= TIFC_VIN_RISE_LO);
	endsequence

	sequence s_trip_high;
		st_ff.ov_rise_select && !st_ff.ov_active && (power_input_rail >= TIFC_VIN_RISE_HI);
	endsequence

	AST_FAULT_BASE: assert property (
		st_ff.fault_temp_select == '0 |-> fault_thr == TIFC_FAULT_BASE_C)
		else $error("lowest fault code not at base temperature");
	AST_FAULT_STEP: assert property (
		st_ff.fault_temp_select != '0
			|-> fault_thr == tifc_fault_thr(st_ff.fault_temp_select - 3'h1) + TIFC_FAULT_STEP_C)
		else $error("fault codes not one step apart");
	AST_FAULT_COLD: assert property (
		die_temp_c < fault_thr && !temp_fault_flag |=> !temp_fault_flag)
		else $error("fault flag set below threshold");
	AST_FAULT_STICKY: assert property (
		temp_fault_flag && !(wr_stat_temp && reg_wdata[TIFC_STAT_FAULT_BIT]) |=> temp_fault_flag)
		else $error("fault flag dropped without clear");
	AST_FAULT_CLEAR: assert property (
		wr_stat_temp && reg_wdata[TIFC_STAT_FAULT_BIT] && !over_fault |=> !temp_fault_flag)
		else $error("fault flag not cleared by host");
	AST_WARN_COLD: assert property (
		die_temp_c < warn_thr && !temp_warning_flag |=> !temp_warning_flag)
		else $error("warning flag set below threshold");
	AST_WARN_CLEAR: assert property (
		wr_stat_temp && reg_wdata[TIFC_STAT_WARN_BIT] && !over_warn |=> !temp_warning_flag)
		else $error("warning flag not cleared by host");
	AST_VIN_STICKY: assert property (
		input_overvoltage_flag && !(wr_stat_input && reg_wdata[TIFC_STAT_VINOV_BIT])
			|=> input_overvoltage_flag)
		else $error("input overvoltage flag dropped without clear");
	AST_VIN_CLEAR: assert property (
		wr_stat_input && reg_wdata[TIFC_STAT_VINOV_BIT] && !input_overvoltage_event |=> !input_overvoltage_flag)
		else $error("input overvoltage flag not cleared by host");
	AST_LATCH_HOLD: assert property (
		s_latched_enabled |=> (st_ff.state == TIFC_LATCHED) && !convert_en)
		else $error("latched stage restarted with enable held");
	AST_REARM: assert property (
		s_rearm |=> (st_ff.state == TIFC_RUN) && !convert_en)
		else $error("enable toggle did not rearm");
	AST_RETRY_COUNT: assert property (
		s_retry_counting |=> (st_ff.state == TIFC_RETRY_WAIT) && !convert_en)
		else $error("retry wait ended early");
	AST_OFF_STATE: assert property (
		st_ff.state != TIFC_RUN |-> !convert_en)
		else $error("stage switching while off");
	AST_ENABLE_LOW: assert property (
		!enable_in |=> !convert_en)
		else $error("stage switching with enable low");
	AST_TRIP_LOW: assert property (
		s_trip_low
			|=> st_ff.ov_active && input_overvoltage_flag && (st_ff.state == TIFC_LATCHED))
		else $error("low rising trip missed");
	AST_TRIP_HIGH: assert property (
		s_trip_high
			|=> st_ff.ov_active && input_overvoltage_flag && (st_ff.state == TIFC_LATCHED))
		else $error("high rising trip missed");
	AST_VIN_RELEASE: assert property (
		st_ff.ov_active && power_input_rail < TIFC_VIN_FALL |=> !st_ff.ov_active)
		else $error("overvoltage not released below falling level");
	AST_RD_HOLD: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read byte changed without a read");
	AST_RSV_TEMP: assert property (
		reg_rd && (reg_addr == TIFC_ADDR_FAULT_THR || reg_addr == TIFC_ADDR_WARN_THR)
			|=> reg_rdata[7:TIFC_SEL_MSB + 1] == 5'h00)
		else $error("temperature limit reserved bits nonzero");
	AST_RSV_VIN: assert property (
		reg_rd && reg_addr == TIFC_ADDR_VIN_THR |=> reg_rdata[7:TIFC_OVSEL_BIT + 1] == 7'h00)
		else $error("input limit reserved bits nonzero");
	AST_WRITE_RETRY: assert property (
		reg_wr && reg_addr == TIFC_ADDR_FAULT_ACT && reg_wdata[TIFC_RETRY_BIT] |=> st_ff.retry_select)
		else $error("retry select write not applied");
	AST_WRITE_VIN: assert property (
		reg_wr && reg_addr == TIFC_ADDR_VIN_THR && !reg_wdata[TIFC_OVSEL_BIT] |=> !st_ff.ov_rise_select)
		else $error("rise select write not applied");
	AST_WRITE_WARN: assert property (
		reg_wr && reg_addr == TIFC_ADDR_WARN_THR |=> st_ff.warning_temp_select == 3'($past(reg_wdata)))
		else $error("warning limit write not applied");

endmodule

`default_nettype wire

//--- tb/tifc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// polling host: no alert line exists, so status is only learned by reads
module tifc_host_model (
	// clock
	input wire logic clk,
	// byte register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// released lines show the inverse, so a stale byte is never mistaken for data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		// return off the edge so callers never sample in the launching time step
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_thermal_input_fault_config.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_thermal_input_fault_config;
	import tifc_pkg::*;
	// short retry wait keeps the run brief
	localparam int RC = 20;
	logic clk, rst_n, reg_wr, reg_rd, nvm_retry_select, nvm_ov_rise_select, enable_in;
	logic convert_en, temp_fault_flag, temp_warning_flag, input_overvoltage_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, die_temp_c, power_input_rail, b;
	logic [2:0] nvm_fault_temp_select, nvm_warning_temp_select;
	int n_errors, n_checks, cycles, n;
	logic [7:0] warn_c [8] = '{8'h55, 8'h5F, 8'h64, 8'h69, 8'h73, 8'h73, 8'h7D, 8'h87};
	logic [7:0] ra [4] = '{8'h4F, 8'h50, 8'h51, 8'h55};
	logic [7:0] rdef [4] = '{8'h05, 8'h08, 8'h02, 8'h01};
	logic [7:0] rmask [4] = '{8'h07, 8'h08, 8'h07, 8'h01};
	tifc_thermal_input_fault #(.RETRY_CYCLES(TIFC_CNT_W'(RC))) tifc_thermal_input_fault_i (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.nvm_fault_temp_select(nvm_fault_temp_select), .nvm_retry_select(nvm_retry_select),
		.nvm_warning_temp_select(nvm_warning_temp_select),
		.nvm_ov_rise_select(nvm_ov_rise_select), .die_temp_c(die_temp_c),
		.power_input_rail(power_input_rail), .enable_in(enable_in), .convert_en(convert_en),
		.temp_fault_flag(temp_fault_flag), .temp_warning_flag(temp_warning_flag),
		.input_overvoltage_flag(input_overvoltage_flag));
	tifc_host_model host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic close_out();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic env(input logic [7:0] t, input logic [7:0] v);
		@(posedge clk);
		die_temp_c <= t;
		power_input_rail <= v;
		repeat (3) @(negedge clk);
	endtask
	task automatic toggle_en();
		@(posedge clk);
		enable_in <= 1'b0;
		repeat (2) @(posedge clk);
		enable_in <= 1'b1;
		repeat (3) @(negedge clk);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			host_i.rd(ra[i], b);
			`CHK(b, rdef[i])
			host_i.wr(ra[i], 8'hFF);
			host_i.rd(ra[i], b);
			`CHK(b, rmask[i])
			host_i.wr(ra[i], 8'h00);
			host_i.rd(ra[i], b);
			`CHK(b, 8'h00)
		end
		host_i.rd(8'h60, b);
		`CHK(b, 8'h00)
	endtask
	task automatic t_fault();
		for (int c = 0; c < 8; c++) begin
			host_i.wr(8'h4F, 8'(c));
			env(TIFC_FAULT_BASE_C + TIFC_FAULT_STEP_C * 8'(c) - 8'h01, 8'h78);
			`CHK(temp_fault_flag, 1'b0)
			env(TIFC_FAULT_BASE_C + TIFC_FAULT_STEP_C * 8'(c), 8'h78);
			`CHK(temp_fault_flag, 1'b1)
			env(8'h3C, 8'h78);
			`CHK(convert_en, 1'b0)
			host_i.rd(8'h7D, b);
			`CHK(b[7], 1'b1)
			host_i.wr(8'h7D, 8'hC0);
			toggle_en();
			`CHK(convert_en, 1'b1)
		end
	endtask
	task automatic t_warn();
		host_i.wr(8'h4F, 8'h07);
		for (int c = 0; c < 8; c++) begin
			host_i.wr(8'h51, 8'(c));
			env(warn_c[c] - 8'h01, 8'h78);
			`CHK(temp_warning_flag, 1'b0)
			env(warn_c[c], 8'h78);
			`CHK(temp_warning_flag, 1'b1)
			env(8'h3C, 8'h78);
			`CHK({temp_warning_flag, convert_en}, 2'b11)
			host_i.rd(8'h7D, b);
			`CHK(b, 8'h40)
			host_i.wr(8'h7D, 8'h40);
		end
	endtask
	task automatic t_retry();
		host_i.wr(8'h50, 8'h08);
		host_i.wr(8'h4F, 8'h00);
		env(8'h78, 8'h78);
		`CHK(convert_en, 1'b0)
		for (int k = 0; k < 2; k++) begin
			n = 0;
			while (convert_en !== 1'b1 && n < 100) begin
				@(negedge clk);
				n++;
			end
			`CHK(n >= RC - 2 && n <= RC + 4, 1'b1)
			@(negedge clk);
		end
		env(8'h3C, 8'h78);
		repeat (RC + 5) @(negedge clk);
		host_i.wr(8'h7D, 8'hC0);
		`CHK(convert_en, 1'b1)
	endtask
	task automatic t_ov();
		host_i.wr(8'h55, 8'h00);
		env(8'h3C, 8'hA8);
		`CHK(input_overvoltage_flag, 1'b0)
		env(8'h3C, 8'hA9);
		`CHK({input_overvoltage_flag, convert_en}, 2'b10)
		host_i.rd(8'h7C, b);
		`CHK(b, 8'h80)
		repeat (RC + 10) @(negedge clk);
		`CHK(convert_en, 1'b0)
		host_i.wr(8'h7C, 8'h80);
		env(8'h3C, 8'h88);
		toggle_en();
		env(8'h3C, 8'hA9);
		`CHK(input_overvoltage_flag, 1'b0)
		env(8'h3C, 8'h86);
		env(8'h3C, 8'hA9);
		`CHK(input_overvoltage_flag, 1'b1)
		env(8'h3C, 8'h86);
		host_i.wr(8'h7C, 8'h80);
		toggle_en();
		host_i.wr(8'h55, 8'h01);
		env(8'h3C, 8'hB9);
		`CHK(input_overvoltage_flag, 1'b0)
		env(8'h3C, 8'hBA);
		`CHK(input_overvoltage_flag, 1'b1)
	endtask
	// mid-run reset: flags clear, limits reload and a latched stage restarts
	task automatic t_reset();
		env(8'h3C, 8'h78);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK({temp_fault_flag, temp_warning_flag, input_overvoltage_flag, convert_en}, 4'h0)
		@(negedge clk);
		`CHK(convert_en, 1'b1)
		host_i.rd(8'h4F, b);
		`CHK(b, 8'h05)
	endtask
	initial begin
		rst_n = 1'b0;
		enable_in = 1'b1;
		die_temp_c = 8'h3C;
		power_input_rail = 8'h78;
		nvm_fault_temp_select = 3'h5;
		nvm_retry_select = 1'b1;
		nvm_warning_temp_select = 3'h2;
		nvm_ov_rise_select = 1'b1;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_fault();
		t_warn();
		t_retry();
		t_ov();
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
